// >>> rtl/debug_run_status_pkg.sv
package debug_run_status_pkg;

    // Register byte addresses
    localparam logic [11:0] STATUS_OFFSET  = 12'h000;
    localparam logic [11:0] CONTROL_OFFSET = 12'h004;
    localparam logic [11:0] IRQ_STAT_OFFSET = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h00c;

    // Status register fields
    localparam int HIT_ONE_BIT   = 7;
    localparam int HIT_TWO_BIT   = 6;
    localparam int RUN_FLAG_BIT  = 5;
    localparam int SPARE_BIT     = 4;
    localparam int COUNT_MSB     = 3;

    // Control register fields
    localparam int ENABLE_BIT    = 7;
    localparam int ARM_BIT       = 6;
    localparam int BEGIN_BIT     = 0;

    // Interrupt status and mask fields
    localparam int IRQ_HIT_ONE   = 0;
    localparam int IRQ_HIT_TWO   = 1;
    localparam int IRQ_RUN_END   = 2;
    localparam int IRQ_WIDTH     = 3;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [3:0] COUNT_RESET   = 4'h0;
    localparam logic [2:0] MASK_RESET    = 3'h0;

    // Capture depth
    localparam int FIFO_DEPTH    = 8;

    typedef enum logic [1:0] {
        IDLE    = 2'b01,
        RUNNING = 2'b10
    } run_state_t;

endpackage

// >>> rtl/run_status_flags.sv
`timescale 1ns/10ps
`default_nettype none
// Sticky hit flags and captured count of one debug run
module run_status_flags
    import debug_run_status_pkg::*;
#(
    parameter int COUNT_W = 4
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Run framing
    input  wire logic               run_start,
    input  wire logic               run_end,
    input  wire logic               running,
    // Events
    input  wire logic               match_one,
    input  wire logic               match_two,
    input  wire logic [COUNT_W-1:0] fifo_level,
    // Status
    output logic                    hit_one_q,
    output logic                    hit_two_q,
    output logic [COUNT_W-1:0]      count_q
);

    logic               hit_one_d;
    logic               hit_two_d;
    logic [COUNT_W-1:0] count_d;

    assign hit_one_d = run_start ? 1'b0 : (hit_one_q | (running & match_one));
    assign hit_two_d = run_start ? 1'b0 : (hit_two_q | (running & match_two));
    // count held, reads do not touch it
    assign count_d   = run_start ? COUNT_W'(0) : (run_end ? fifo_level : count_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_one_q <= 1'b0;
            hit_two_q <= 1'b0;
            count_q   <= COUNT_W'(COUNT_RESET);
        end else begin
            hit_one_q <= hit_one_d;
            hit_two_q <= hit_two_d;
            count_q   <= count_d;
        end
    end

    hit_one_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_start |=> !hit_one_q) else $error("hit one not cleared at run start");
    hit_two_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (running && !run_start && match_two) |=> hit_two_q) else $error("hit two not set");
    count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!run_start && !run_end) |=> $stable(count_q)) else $error("count changed mid-idle");
    count_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (run_end && !run_start) |=> count_q == $past(fifo_level)) else $error("count not captured");

endmodule
`default_nettype wire

// >>> rtl/debug_run_status.sv
`timescale 1ns/10ps
`default_nettype none
module debug_run_status
    import debug_run_status_pkg::*;
#(
    parameter int COUNT_W = 4
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Debug unit events
    input  wire logic               match_one,
    input  wire logic               match_two,
    input  wire logic               trigger_event,
    input  wire logic               fifo_full,
    input  wire logic [COUNT_W-1:0] fifo_level,
    // Control and status to the debug unit
    output logic                    run_active,
    output logic                    irq
);
    import debug_run_status_pkg::*;

    run_state_t          state_q;
    run_state_t          state_d;
    logic [7:0]          ctrl_q;
    logic [7:0]          ctrl_d;
    logic [IRQ_WIDTH-1:0] istat_q;
    logic [IRQ_WIDTH-1:0] istat_d;
    logic [IRQ_WIDTH-1:0] imask_q;
    logic [31:0]         prdata_d;
    logic                hit_one;
    logic                hit_two;
    logic [COUNT_W-1:0]  count;

    // Decode
    wire access     = psel & penable;
    wire wr_en      = access & pwrite;
    wire rd_en      = access & ~pwrite;
    wire hit_status = paddr == STATUS_OFFSET;
    wire hit_ctrl   = paddr == CONTROL_OFFSET;
    wire hit_istat  = paddr == IRQ_STAT_OFFSET;
    wire hit_imask  = paddr == IRQ_MASK_OFFSET;
    wire mapped     = hit_status | hit_ctrl | hit_istat | hit_imask;
    wire ctrl_wr    = wr_en & hit_ctrl;
    wire enabled    = ctrl_q[ENABLE_BIT];
    wire armed      = ctrl_q[ARM_BIT];
    wire begin_mode = ctrl_q[BEGIN_BIT];
    wire running    = state_q == RUNNING;

    // write setting both enable and arm starts a run when idle
    wire arm_req    = ctrl_wr & pwdata[ENABLE_BIT] & pwdata[ARM_BIT] & ~running;
    wire run_start  = arm_req;
    wire run_done   = running & (begin_mode ? fifo_full : trigger_event);
    wire run_abort  = running & ctrl_wr & ~(pwdata[ENABLE_BIT] & pwdata[ARM_BIT]);
    wire run_end    = run_done | run_abort;

    // State machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            IDLE: begin
                if (run_start) begin
                    state_d = RUNNING;
                end
            end
            RUNNING: begin
                if (run_end) begin
                    state_d = IDLE;
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    // Arm bit cleared by hardware when the run completes
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = pwdata[7:0];
            ctrl_d[ARM_BIT] = pwdata[ARM_BIT] & pwdata[ENABLE_BIT];
        end
        // A control write in the completion cycle must not keep the arm bit alive
        if (run_done) begin
            ctrl_d[ARM_BIT] = 1'b0;
        end
    end

    // Events set sticky bits; set wins over the read clear
    wire [IRQ_WIDTH-1:0] ev = {run_end, running & match_two, running & match_one};
    wire istat_rd = rd_en & hit_istat;
    // Clear only what the setup cycle reported, so an event landing in between is kept
    assign istat_d = (istat_rd ? (istat_q & ~prdata[IRQ_WIDTH-1:0]) : istat_q) | ev;

    wire [7:0] status_byte = {hit_one, hit_two, enabled & armed, 1'b0, count};

    // status register has no write path
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (hit_status) begin
            prdata_d = {24'h00_0000, status_byte};
        end else if (hit_ctrl) begin
            prdata_d = {24'h00_0000, ctrl_q};
        end else if (hit_istat) begin
            prdata_d = {29'h0000_0000, istat_q};
        end else if (hit_imask) begin
            prdata_d = {29'h0000_0000, imask_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= IDLE;
            ctrl_q  <= CONTROL_RESET;
            istat_q <= {IRQ_WIDTH{1'b0}};
            imask_q <= MASK_RESET;
        end else begin
            state_q <= state_d;
            ctrl_q  <= ctrl_d;
            istat_q <= istat_d;
            if (wr_en && hit_imask) begin
                imask_q <= pwdata[IRQ_WIDTH-1:0];
            end
        end
    end

    // Answer in the first access cycle; read data registered at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            run_active <= 1'b0;
            irq        <= 1'b0;
        end else begin
            pready     <= psel & ~penable;
            pslverr    <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= prdata_d;
            end
            run_active <= state_d == RUNNING;
            irq        <= |(istat_d & imask_q);
        end
    end

    run_status_flags #(
        .COUNT_W   (COUNT_W)
    ) u_flags (
        .pclk       (pclk),
        .presetn    (presetn),
        .run_start  (run_start),
        .run_end    (run_end),
        .running    (running),
        .match_one  (match_one),
        .match_two  (match_two),
        .fifo_level (fifo_level),
        .hit_one_q  (hit_one),
        .hit_two_q  (hit_two),
        .count_q    (count)
    );

    sequence arm_write_s;
        ctrl_wr && pwdata[ENABLE_BIT] && pwdata[ARM_BIT] && !running;
    endsequence
    run_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        arm_write_s |=> running && run_active) else $error("run did not start");
    full_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (running && begin_mode && fifo_full) |=> !running && !armed) else $error("full did not end run");
    trig_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (running && !begin_mode && trigger_event && !ctrl_wr) |=> !running)
        else $error("trigger did not end run");
    manual_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (running && ctrl_wr && !pwdata[ARM_BIT]) |=> !running) else $error("manual stop ignored");
    mirror_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_status && enabled) |=> prdata[RUN_FLAG_BIT] == $past(armed))
        else $error("run flag not mirroring arm");
    spare_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && hit_status && !pwrite) |-> prdata[SPARE_BIT] == 1'b0) else $error("spare bit set");
    status_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_status && !running && !run_start) |=> $stable(count))
        else $error("status write changed count");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |($past(istat_d) & $past(imask_q))) else $error("irq mismatch");

endmodule
`default_nettype wire

// >>> verification/debug_unit_model.sv
`timescale 1ns/10ps
`default_nettype none
// Comparators and capture FIFO on the far side of the status block
module debug_unit_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Bench commands
    input  wire logic       fill,
    input  wire logic       drain,
    input  wire logic [2:0] fire,
    // Events to the block
    output logic            match_one,
    output logic            match_two,
    output logic            trigger_event,
    output logic            fifo_full,
    output logic [3:0]      fifo_level
);
    logic [3:0] level_q;
    logic [3:0] taken_q;
    assign match_one     = fire[0];
    assign match_two     = fire[1];
    assign trigger_event = fire[2];
    assign fifo_level    = level_q;
    assign fifo_full     = (level_q == 4'h8);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 4'h0;
            taken_q <= 4'h0;
        end else if (fill && !fifo_full) begin
            level_q <= level_q + 4'h1;
        end else if (drain && level_q != 4'h0) begin
            level_q <= level_q - 4'h1;
            taken_q <= taken_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/debug_run_status_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module debug_run_status_tb_top;
    import debug_run_status_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        match_one;
    logic        match_two;
    logic        trigger_event;
    logic        fifo_full;
    logic [3:0]  fifo_level;
    logic        run_active;
    logic        irq;
    logic        fill;
    logic        drain;
    logic [2:0]  fire;
    logic [31:0] rd;
    logic        err;
    int          n_fail;
    int          checks_done;

    debug_run_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .match_one(match_one), .match_two(match_two),
        .trigger_event(trigger_event), .fifo_full(fifo_full), .fifo_level(fifo_level),
        .run_active(run_active), .irq(irq));
    debug_unit_model u_far (.pclk(pclk), .presetn(presetn), .fill(fill), .drain(drain),
        .fire(fire), .match_one(match_one), .match_two(match_two),
        .trigger_event(trigger_event), .fifo_full(fifo_full), .fifo_level(fifo_level));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Held until pready is seen high; one idle edge after so strobes never toggle twice
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        clk(1);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            clk(1);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        clk(1);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pulse(input logic [2:0] f);
        fire <= f;
        clk(1);
        fire <= 3'h0;
        clk(2);
    endtask

    task automatic t_reset;
        rdchk(STATUS_OFFSET, 32'h0);
        rdchk(CONTROL_OFFSET, {24'h0, CONTROL_RESET});
        rdchk(IRQ_MASK_OFFSET, {29'h0, MASK_RESET});
        apb(1'b1, 12'h010, 32'h0);
        chk(32'(err), 32'h1);
    endtask

    task automatic t_begin_run;
        apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
        apb(1'b1, CONTROL_OFFSET, 32'hc1);
        clk(1);
        chk(32'(run_active), 32'h1);
        rdchk(STATUS_OFFSET, 32'h20);
        pulse(3'h1);
        chk(32'(irq), 32'h1);
        rdchk(IRQ_STAT_OFFSET, 32'h1);
        chk(32'(irq), 32'h0);
        rdchk(STATUS_OFFSET, 32'ha0);
        // Fill past depth: the level saturates at full
        fill <= 1'b1;
        clk(10);
        fill <= 1'b0;
        clk(2);
        chk(32'(run_active), 32'h0);
        chk(32'(irq), 32'h0);
        rdchk(STATUS_OFFSET, 32'h88);
        rdchk(CONTROL_OFFSET, 32'h81);
        drain <= 1'b1;
        clk(3);
        drain <= 1'b0;
        clk(1);
        chk(32'(u_far.taken_q), 32'h3);
        rdchk(STATUS_OFFSET, 32'h88);
        apb(1'b1, STATUS_OFFSET, 32'hff);
        rdchk(STATUS_OFFSET, 32'h88);
    endtask

    task automatic t_end_run;
        rdchk(IRQ_STAT_OFFSET, 32'h4);
        apb(1'b1, IRQ_MASK_OFFSET, 32'h4);
        apb(1'b1, CONTROL_OFFSET, 32'hc0);
        clk(1);
        rdchk(STATUS_OFFSET, 32'h20);
        pulse(3'h2);
        rdchk(STATUS_OFFSET, 32'h60);
        pulse(3'h4);
        chk(32'(irq), 32'h1);
        chk(32'(run_active), 32'h0);
        rdchk(STATUS_OFFSET, 32'h45);
        rdchk(IRQ_STAT_OFFSET, 32'h6);
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_abort;
        apb(1'b1, CONTROL_OFFSET, 32'hc0);
        clk(1);
        chk(32'(run_active), 32'h1);
        drain <= 1'b1;
        clk(2);
        drain <= 1'b0;
        apb(1'b1, CONTROL_OFFSET, 32'h80);
        clk(1);
        chk(32'(run_active), 32'h0);
        pulse(3'h1);
        rdchk(STATUS_OFFSET, 32'h03);
        apb(1'b1, CONTROL_OFFSET, 32'hc0);
        apb(1'b1, CONTROL_OFFSET, 32'h40);
        clk(1);
        chk(32'(run_active), 32'h0);
        rdchk(STATUS_OFFSET, 32'h03);
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {presetn, psel, penable, pwrite, fill, drain} = 6'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fire = 3'h0;
        n_fail = 0;
        checks_done = 0;
        clk(4);
        presetn <= 1'b1;
        clk(1);
        t_reset();
        t_begin_run();
        t_end_run();
        t_abort();
        tally_and_finish();
    end
endmodule
`default_nettype wire
